// ### pkg/gpw_pkg.sv
// constants shared by the gpio port block
package gpw_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int PA_W = 8;
  localparam int PB_W = 6;

  // register offsets
  localparam logic [3:0] OFS_PA_DATA = 4'h0;
  localparam logic [3:0] OFS_PB_DATA = 4'h1;
  localparam logic [3:0] OFS_PA_DIR = 4'h2;
  localparam logic [3:0] OFS_PB_DIR = 4'h3;
  localparam logic [3:0] OFS_PA_PH = 4'h4;
  localparam logic [3:0] OFS_PB_PH = 4'h5;
  localparam logic [3:0] OFS_PL = 4'h6;
  localparam logic [3:0] OFS_PB_OD = 4'h7;
  localparam logic [3:0] OFS_PA_WAKE = 4'h8;
  localparam logic [3:0] OFS_PB_WAKE = 4'h9;
  localparam logic [3:0] OFS_IRQ_FLAG = 4'hA;
  localparam logic [3:0] OFS_IRQ_EN = 4'hB;
  localparam logic [3:0] OFS_IRQ_EDGE = 4'hC;
  localparam logic [3:0] OFS_PWR = 4'hD;
  localparam logic [3:0] OFS_ALT = 4'hE;
  localparam logic [3:0] OFS_TSRC = 4'hF;

  // reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_DIR = 8'hFF;

  // irq flag / enable bits
  localparam int IRQ_CHG_BIT = 1;
  localparam int IRQ_EXT0_BIT = 2;
  localparam int IRQ_EXT1_BIT = 3;
  localparam logic [7:0] IRQ_USED = 8'h0E;

  // edge register fields
  localparam int EDG0_LO = 0;
  localparam int EDG1_LO = 2;
  localparam int EXT_IRQ0_SELECT_BIT = 4;
  localparam int EXT_IRQ1_SELECT_BIT = 5;

  // power control fields
  localparam int PWR_PA5_PH_BIT = 4;
  localparam int PWR_GIE_BIT = 7;

  // pull-low layout: shared register fields, and the pa5 bit in the pa pull-high reg
  localparam int PL_PA_LO = 0;
  localparam int PL_PB_LO = 4;
  localparam int PA5_PL_BIT = 5;

  // alternate function control fields
  localparam int ALT_IR_BIT = 0;
  localparam int ALT_CMP_BIT = 1;
  localparam int ALT_PWM1_BIT = 2;
  localparam int ALT_BZ1_BIT = 3;
  localparam int ALT_PWM2_BIT = 4;
  localparam int ALT_BZ2_BIT = 5;

  // timer source fields
  localparam int TS_TIMER0_CLOCK_SELECT_BIT = 0;
  localparam int TS_T0LCK_BIT = 1;
  localparam int TS_TIMER1_CLOCK_SELECT_BIT = 2;
  localparam int TS_TIMER2_CLOCK_SELECT_BIT = 3;
  localparam int TS_TIMER3_CLOCK_SELECT_BIT = 4;

  // pad indices with special duties
  localparam int PAD_TCLK_B = 1;
  localparam int PAD_TCLK_A = 4;
  localparam int PAD_RST = 5;
  localparam int PAD_XIN = 6;
  localparam int PAD_XOUT = 7;
  localparam int PAD_EXT0 = 0;
  localparam int PAD_EXT1 = 1;
  localparam int PAD_PB2 = 2;
  localparam int PAD_PB3 = 3;

endpackage

// ### hdl/gpw_pin_sync.sv
// pin synchroniser with level-change detection
`timescale 1ns/1ps
module gpw_pin_sync #(
  parameter int W = 8
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;
  logic [W-1:0] prev_reg;

  ////////////////////////////////////////////////////////////////////////
  // first stage is read only by the second stage
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
      prev_reg <= '0;
    end
    else
    begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign level = sync_reg;
  assign rise = sync_reg & ~prev_reg;
  assign fall = ~sync_reg & prev_reg;

endmodule

// ### hdl/gpw_port.sv
// gpio ports a and b with pulls, open-drain, level-change and pad muxing
// What this block does
// [RQ1] fourteen pins, port a eight and port b six, each with a data register
// [RQ2] each pin has its own direction bit, eight for a and six for b
// [RQ3] pull-high: pa7:6,4:0 from a pull-high reg, pa5 from power bit 4, pb all
// [RQ4] pull-low: pa5 from a pull-high bit 5, pa3:0 and pb3:0 from shared reg
// [RQ5] port b open-drain per bit when output; pa5 always open-drain
// [RQ6] any change on a wake-selected pin other than a crystal pad or an external-interrupt pb0/pb1 sets port change flag, flag bit 1
// [RQ7] port change irq needs flag, enable bit 1 and global enable bit 7
// [RQ8] edge register bits 4 and 5 make pb0 and pb1 external interrupt inputs
// [RQ9] external interrupt beats level change on pb0 and pb1; pb5:2 unaffected
// [RQ10] ir carrier enable drives carrier onto pb1; otherwise no carrier
// [RQ11] with external reset selected, low on pa5 starts chip reset
// [RQ12] external crystal makes pa6 crystal input and pa7 crystal output
// [RQ13] internal rc only plus config enable puts instruction clock on pa7
// [RQ14] pa4 feeds timer0 when selected and not low-clock, and timer1 if selected
// [RQ15] pa1 feeds timer2 or timer3 when that timer selects external clock
// [RQ16] pb3 priority: comparator, then pwm1, then buzzer1
// [RQ17] pb2 priority: pwm2 over buzzer2
// [RQ18] sink strength per port: select 0 normal, select 1 large, short bit 0
// [RQ19] data write updates latch; output pin drives latch unless alt owns pad
`timescale 1ns/1ps
module gpw_port (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [gpw_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [gpw_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [gpw_pkg::DATA_W-1:0] reg_rdata,
  output logic irq,
  input wire logic [gpw_pkg::PA_W-1:0] pa_in,
  output logic [gpw_pkg::PA_W-1:0] pa_out,
  output logic [gpw_pkg::PA_W-1:0] pa_oe_n,
  output logic [gpw_pkg::PA_W-1:0] pa_pullhigh_en,
  output logic [gpw_pkg::PA_W-1:0] pa_pulllow_en,
  input wire logic [gpw_pkg::PB_W-1:0] pb_in,
  output logic [gpw_pkg::PB_W-1:0] pb_out,
  output logic [gpw_pkg::PB_W-1:0] pb_oe_n,
  output logic [gpw_pkg::PB_W-1:0] pb_pullhigh_en,
  output logic [gpw_pkg::PB_W-1:0] pb_pulllow_en,
  input wire logic ext_reset_enable,
  input wire logic ext_high_crystal,
  input wire logic ext_crystal,
  input wire logic ext_low_crystal,
  input wire logic clock_out_enable,
  input wire logic instr_clk_level,
  input wire logic sink_current_select_a,
  input wire logic sink_short_select_a,
  input wire logic sink_current_select_b,
  input wire logic sink_short_select_b,
  input wire logic ir_carrier,
  input wire logic comparator_out,
  input wire logic pwm1_out,
  input wire logic buzzer1_out,
  input wire logic pwm2_out,
  input wire logic buzzer2_out,
  output logic ext_reset_req,
  output logic crystal_mode,
  output logic ext_timer_clock_a_t0,
  output logic ext_timer_clock_a_t1,
  output logic ext_timer_clock_b,
  output logic ir_carrier_enable,
  output logic large_sink_a,
  output logic large_sink_b
);
  import gpw_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [PA_W-1:0] port_a_data_reg;
    logic [PB_W-1:0] port_b_data_reg;
    logic [PA_W-1:0] port_a_direction;
    logic [PB_W-1:0] port_b_direction;
    logic [PA_W-1:0] port_a_pullhigh_ctl;
    logic [PB_W-1:0] port_b_pullhigh_ctl;
    logic [DATA_W-1:0] shared_pulllow_ctl;
    logic [PB_W-1:0] port_b_opendrain_ctl;
    logic [PA_W-1:0] port_a_wake_select;
    logic [PB_W-1:0] port_b_wake_select;
    logic [DATA_W-1:0] irq_flag_reg, irq_enable_reg, irq_edge_reg, power_ctl_reg;
    logic [DATA_W-1:0] alt_func_ctl, timer_src_ctl, rdata;
    logic irq;
    logic [PA_W-1:0] pa_out, pa_oe_n;
    logic [PB_W-1:0] pb_out, pb_oe_n;
    logic ext_reset_req, tclk_a_t0, tclk_a_t1, tclk_b;
  } gpw_state_s;

  gpw_state_s state_reg;
  gpw_state_s state_next;

  logic [PA_W-1:0] pa_lvl, pa_rise, pa_fall;
  logic [PB_W-1:0] pb_lvl, pb_rise, pb_fall;
  logic [PA_W-1:0] rd_a, a_out, a_drive;
  logic [PB_W-1:0] rd_b, b_out, b_drive, b_od;

  ////////////////////////////////////////////////////////////////////////
  gpw_pin_sync #(
    .W(PA_W)
  ) u_sync_a (
    .sys_clk(sys_clk),
    .reset(reset),
    .pin_in(pa_in),
    .level(pa_lvl),
    .rise(pa_rise),
    .fall(pa_fall)
  );

  gpw_pin_sync #(
    .W(PB_W)
  ) u_sync_b (
    .sys_clk(sys_clk),
    .reset(reset),
    .pin_in(pb_in),
    .level(pb_lvl),
    .rise(pb_rise),
    .fall(pb_fall)
  );

  ////////////////////////////////////////////////////////////////////////
  // static pad decisions
  logic xtal_on, clk_on_pa7, ext0_sel, ext1_sel, chg_event, ext0_event, ext1_event;
  logic [PA_W-1:0] pa_in_mode;
  logic [PB_W-1:0] pb_in_mode, ext_mask;

  assign xtal_on = ext_high_crystal | ext_crystal | ext_low_crystal; // [RQ12]
  assign clk_on_pa7 = clock_out_enable & ~xtal_on; // [RQ13]
  assign ext0_sel = state_reg.irq_edge_reg[EXT_IRQ0_SELECT_BIT]; // [RQ8]
  assign ext1_sel = state_reg.irq_edge_reg[EXT_IRQ1_SELECT_BIT]; // [RQ8]
  assign pa_in_mode = state_reg.port_a_direction;
  assign pb_in_mode = state_reg.port_b_direction;

  // external interrupt takes pb0/pb1 out of level-change detection
  always_comb
  begin
    ext_mask = '1;
    ext_mask[PAD_EXT0] = ~ext0_sel; // [RQ9]
    ext_mask[PAD_EXT1] = ~ext1_sel; // [RQ9]
  end

  // crystal pads do not take part in change detection
  logic [PA_W-1:0] pa_chg_mask;
  always_comb
  begin
    pa_chg_mask = '1;
    pa_chg_mask[PAD_XIN] = ~xtal_on;
    pa_chg_mask[PAD_XOUT] = ~xtal_on;
  end

  assign chg_event = |((pa_rise | pa_fall) & state_reg.port_a_wake_select & pa_chg_mask)
    | |((pb_rise | pb_fall) & state_reg.port_b_wake_select & ext_mask); // [RQ6] [RQ9]

  // edge code: bit0 selects falling, bit1 selects both edges
  function automatic logic edge_hit(input logic [1:0] code, input logic r, input logic f);
    edge_hit = code[1] ? (r | f) : (code[0] ? f : r);
  endfunction

  assign ext0_event = ext0_sel & edge_hit(state_reg.irq_edge_reg[EDG0_LO +: 2],
    pb_rise[PAD_EXT0], pb_fall[PAD_EXT0]); // [RQ8]
  assign ext1_event = ext1_sel & edge_hit(state_reg.irq_edge_reg[EDG1_LO +: 2],
    pb_rise[PAD_EXT1], pb_fall[PAD_EXT1]); // [RQ8]

  ////////////////////////////////////////////////////////////////////////
  // register access and state update
  always_comb
  begin
    logic [DATA_W-1:0] set_bits, clr_bits;
    set_bits = '0;
    clr_bits = '0;
    state_next = state_reg;
    state_next.rdata = RST_ZERO;

    if (reg_write)
    begin
      if (reg_addr == OFS_PA_DATA)
        state_next.port_a_data_reg = reg_wdata[PA_W-1:0]; // [RQ1] [RQ19]
      else if (reg_addr == OFS_PB_DATA)
        state_next.port_b_data_reg = reg_wdata[PB_W-1:0]; // [RQ1] [RQ19]
      else if (reg_addr == OFS_PA_DIR)
        state_next.port_a_direction = reg_wdata[PA_W-1:0]; // [RQ2]
      else if (reg_addr == OFS_PB_DIR)
        state_next.port_b_direction = reg_wdata[PB_W-1:0]; // [RQ2]
      else if (reg_addr == OFS_PA_PH)
        state_next.port_a_pullhigh_ctl = reg_wdata[PA_W-1:0];
      else if (reg_addr == OFS_PB_PH)
        state_next.port_b_pullhigh_ctl = reg_wdata[PB_W-1:0];
      else if (reg_addr == OFS_PL)
        state_next.shared_pulllow_ctl = reg_wdata;
      else if (reg_addr == OFS_PB_OD)
        state_next.port_b_opendrain_ctl = reg_wdata[PB_W-1:0];
      else if (reg_addr == OFS_PA_WAKE)
        state_next.port_a_wake_select = reg_wdata[PA_W-1:0];
      else if (reg_addr == OFS_PB_WAKE)
        state_next.port_b_wake_select = reg_wdata[PB_W-1:0];
      else if (reg_addr == OFS_IRQ_FLAG)
        clr_bits = reg_wdata & IRQ_USED;
      else if (reg_addr == OFS_IRQ_EN)
        state_next.irq_enable_reg = reg_wdata & IRQ_USED;
      else if (reg_addr == OFS_IRQ_EDGE)
        state_next.irq_edge_reg = reg_wdata;
      else if (reg_addr == OFS_PWR)
        state_next.power_ctl_reg = reg_wdata;
      else if (reg_addr == OFS_ALT)
        state_next.alt_func_ctl = reg_wdata;
      else
        state_next.timer_src_ctl = reg_wdata;
    end

    // inputs read the pin, outputs read the latch
    rd_a = (pa_lvl & pa_in_mode) | (state_reg.port_a_data_reg & ~pa_in_mode); // [RQ1]
    rd_b = (pb_lvl & pb_in_mode) | (state_reg.port_b_data_reg & ~pb_in_mode); // [RQ1]

    if (reg_read)
    begin
      if (reg_addr == OFS_PA_DATA)
        state_next.rdata = rd_a;
      else if (reg_addr == OFS_PB_DATA)
        state_next.rdata = {2'b00, rd_b};
      else if (reg_addr == OFS_PA_DIR)
        state_next.rdata = state_reg.port_a_direction;
      else if (reg_addr == OFS_PB_DIR)
        state_next.rdata = {2'b00, state_reg.port_b_direction};
      else if (reg_addr == OFS_PA_PH)
        state_next.rdata = state_reg.port_a_pullhigh_ctl;
      else if (reg_addr == OFS_PB_PH)
        state_next.rdata = {2'b00, state_reg.port_b_pullhigh_ctl};
      else if (reg_addr == OFS_PL)
        state_next.rdata = state_reg.shared_pulllow_ctl;
      else if (reg_addr == OFS_PB_OD)
        state_next.rdata = {2'b00, state_reg.port_b_opendrain_ctl};
      else if (reg_addr == OFS_PA_WAKE)
        state_next.rdata = state_reg.port_a_wake_select;
      else if (reg_addr == OFS_PB_WAKE)
        state_next.rdata = {2'b00, state_reg.port_b_wake_select};
      else if (reg_addr == OFS_IRQ_FLAG)
        state_next.rdata = state_reg.irq_flag_reg;
      else if (reg_addr == OFS_IRQ_EN)
        state_next.rdata = state_reg.irq_enable_reg;
      else if (reg_addr == OFS_IRQ_EDGE)
        state_next.rdata = state_reg.irq_edge_reg;
      else if (reg_addr == OFS_PWR)
        state_next.rdata = state_reg.power_ctl_reg;
      else if (reg_addr == OFS_ALT)
        state_next.rdata = state_reg.alt_func_ctl;
      else
        state_next.rdata = state_reg.timer_src_ctl;
    end

    // sticky flags: a new event in the clearing cycle survives
    set_bits[IRQ_CHG_BIT] = chg_event; // [RQ6]
    set_bits[IRQ_EXT0_BIT] = ext0_event; // [RQ8]
    set_bits[IRQ_EXT1_BIT] = ext1_event; // [RQ8]
    state_next.irq_flag_reg = (state_reg.irq_flag_reg & ~clr_bits) | set_bits;
    state_next.irq = state_next.power_ctl_reg[PWR_GIE_BIT]
      & |(state_next.irq_flag_reg & state_next.irq_enable_reg); // [RQ7]

    // port a: latch on output pins, alternate duties override
    a_out = state_reg.port_a_data_reg; // [RQ19]
    a_drive = ~pa_in_mode; // [RQ2]
    // pa5 is open-drain: it only ever pulls low
    a_drive[PAD_RST] = ~pa_in_mode[PAD_RST] & ~a_out[PAD_RST]
      & ~ext_reset_enable; // [RQ5] [RQ11]
    a_out[PAD_RST] = 1'b0; // [RQ5]
    if (clk_on_pa7)
      a_out[PAD_XOUT] = instr_clk_level; // [RQ13]
    a_drive[PAD_XOUT] = (a_drive[PAD_XOUT] | clk_on_pa7) & ~xtal_on; // [RQ12] [RQ13]
    a_drive[PAD_XIN] = a_drive[PAD_XIN] & ~xtal_on; // [RQ12]

    // port b: latch first, then alternate outputs in priority order
    b_out = state_reg.port_b_data_reg; // [RQ19]
    b_drive = ~pb_in_mode; // [RQ2]
    if (state_reg.alt_func_ctl[ALT_CMP_BIT])
      b_out[PAD_PB3] = comparator_out; // [RQ16]
    else if (state_reg.alt_func_ctl[ALT_PWM1_BIT])
      b_out[PAD_PB3] = pwm1_out; // [RQ16]
    else if (state_reg.alt_func_ctl[ALT_BZ1_BIT])
      b_out[PAD_PB3] = buzzer1_out; // [RQ16]
    if (state_reg.alt_func_ctl[ALT_PWM2_BIT])
      b_out[PAD_PB2] = pwm2_out; // [RQ17]
    else if (state_reg.alt_func_ctl[ALT_BZ2_BIT])
      b_out[PAD_PB2] = buzzer2_out; // [RQ17]
    if (state_reg.alt_func_ctl[ALT_IR_BIT])
      b_out[PAD_EXT1] = ir_carrier; // [RQ10]
    b_drive[PAD_PB3] |= |state_reg.alt_func_ctl[ALT_BZ1_BIT:ALT_CMP_BIT]; // [RQ16]
    b_drive[PAD_PB2] |= |state_reg.alt_func_ctl[ALT_BZ2_BIT:ALT_PWM2_BIT]; // [RQ17]
    b_drive[PAD_EXT1] |= state_reg.alt_func_ctl[ALT_IR_BIT]; // [RQ10]
    // open-drain pins only sink; a high level releases the pad
    b_od = state_reg.port_b_opendrain_ctl & ~pb_in_mode; // [RQ5]
    b_drive = b_drive & ~(b_od & b_out); // [RQ5]
    b_out = b_out & ~b_od; // [RQ5]

    state_next.pa_out = a_out;
    state_next.pa_oe_n = ~a_drive;
    state_next.pb_out = b_out;
    state_next.pb_oe_n = ~b_drive;

    // synchronised level, so reset sees no metastable pad
    state_next.ext_reset_req = ext_reset_enable & ~pa_lvl[PAD_RST]; // [RQ11]
    state_next.tclk_a_t0 = state_reg.timer_src_ctl[TS_TIMER0_CLOCK_SELECT_BIT]
      & ~state_reg.timer_src_ctl[TS_T0LCK_BIT] & pa_lvl[PAD_TCLK_A]; // [RQ14]
    state_next.tclk_a_t1 = state_reg.timer_src_ctl[TS_TIMER1_CLOCK_SELECT_BIT]
      & pa_lvl[PAD_TCLK_A]; // [RQ14]
    state_next.tclk_b = (state_reg.timer_src_ctl[TS_TIMER2_CLOCK_SELECT_BIT]
      | state_reg.timer_src_ctl[TS_TIMER3_CLOCK_SELECT_BIT]) & pa_lvl[PAD_TCLK_B]; // [RQ15]
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      state_reg <= '0;
      state_reg.port_a_direction <= RST_DIR[PA_W-1:0];
      state_reg.port_b_direction <= RST_DIR[PB_W-1:0];
      state_reg.pa_oe_n <= RST_DIR[PA_W-1:0];
      state_reg.pb_oe_n <= RST_DIR[PB_W-1:0];
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pulls act only on input pads; crystal pads carry none
  always_comb
  begin
    pa_pullhigh_en = state_reg.port_a_pullhigh_ctl & pa_in_mode & pa_chg_mask; // [RQ3]
    pa_pullhigh_en[PAD_RST] = state_reg.power_ctl_reg[PWR_PA5_PH_BIT]
      & pa_in_mode[PAD_RST]; // [RQ3]
    pa_pulllow_en = '0;
    pa_pulllow_en[3:0] = state_reg.shared_pulllow_ctl[PL_PA_LO +: 4] & pa_in_mode[3:0]; // [RQ4]
    pa_pulllow_en[PAD_RST] = state_reg.port_a_pullhigh_ctl[PA5_PL_BIT]
      & pa_in_mode[PAD_RST]; // [RQ4]
    pb_pullhigh_en = state_reg.port_b_pullhigh_ctl & pb_in_mode; // [RQ3]
    pb_pulllow_en = '0;
    pb_pulllow_en[3:0] = state_reg.shared_pulllow_ctl[PL_PB_LO +: 4] & pb_in_mode[3:0]; // [RQ4]
  end

  assign reg_rdata = state_reg.rdata;
  assign irq = state_reg.irq;
  assign pa_out = state_reg.pa_out;
  assign pa_oe_n = state_reg.pa_oe_n;
  assign pb_out = state_reg.pb_out;
  assign pb_oe_n = state_reg.pb_oe_n;
  assign ext_reset_req = state_reg.ext_reset_req;
  assign crystal_mode = xtal_on; // [RQ12]
  assign ext_timer_clock_a_t0 = state_reg.tclk_a_t0;
  assign ext_timer_clock_a_t1 = state_reg.tclk_a_t1;
  assign ext_timer_clock_b = state_reg.tclk_b;
  assign ir_carrier_enable = state_reg.alt_func_ctl[ALT_IR_BIT]; // [RQ10]
  assign large_sink_a = sink_current_select_a & ~sink_short_select_a; // [RQ18]
  assign large_sink_b = sink_current_select_b & ~sink_short_select_b; // [RQ18]

endmodule

// ### verif/gpw_port_properties.sv
// concurrent checks on the gpio port block pins
`timescale 1ns/1ps
module gpw_port_properties (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic reg_read,
  input wire logic [gpw_pkg::DATA_W-1:0] reg_rdata,
  input wire logic irq,
  input wire logic [gpw_pkg::PA_W-1:0] pa_in,
  input wire logic [gpw_pkg::PA_W-1:0] pa_out,
  input wire logic [gpw_pkg::PA_W-1:0] pa_oe_n,
  input wire logic [gpw_pkg::PA_W-1:0] pa_pulllow_en,
  input wire logic [gpw_pkg::PB_W-1:0] pb_out,
  input wire logic [gpw_pkg::PB_W-1:0] pb_oe_n,
  input wire logic [gpw_pkg::PB_W-1:0] pb_pulllow_en,
  input wire logic ext_reset_enable,
  input wire logic ext_high_crystal,
  input wire logic ext_crystal,
  input wire logic ext_low_crystal,
  input wire logic sink_current_select_a,
  input wire logic sink_short_select_a,
  input wire logic sink_current_select_b,
  input wire logic sink_short_select_b,
  input wire logic ir_carrier,
  input wire logic ext_reset_req,
  input wire logic crystal_mode,
  input wire logic ir_carrier_enable,
  input wire logic large_sink_a,
  input wire logic large_sink_b
);
  import gpw_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////////////
  a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("read data seen without a read");
  a_reset_quiet: assert property ($fell(reset) |-> !irq && &pa_oe_n && &pb_oe_n)
    else $error("pins driven or irq high after reset");
  a_no_pulllow: assert property (pa_pulllow_en[7:6] == 2'h0 && !pa_pulllow_en[4]
    && pb_pulllow_en[5:4] == 2'h0) else $error("pull-low on a pin without one");
  a_pa5_drain: assert property (!pa_oe_n[PAD_RST] |-> !pa_out[PAD_RST])
    else $error("pa5 driven high");
  a_ext_reset_on: assert property ((ext_reset_enable && !pa_in[5])[*4] |-> ext_reset_req)
    else $error("low pa5 gave no reset request");
  a_ext_reset_off: assert property (!ext_reset_enable |=> !ext_reset_req)
    else $error("reset request while external reset off");
  a_crystal_mode: assert property (crystal_mode == (ext_high_crystal | ext_crystal
    | ext_low_crystal)) else $error("crystal mode mismatch");
  a_sink_a: assert property (large_sink_a == (sink_current_select_a & ~sink_short_select_a))
    else $error("port a sink strength mismatch");
  a_sink_b: assert property (large_sink_b == (sink_current_select_b & ~sink_short_select_b))
    else $error("port b sink strength mismatch");
  // a released open-drain pad carries nothing
  a_ir_pad: assert property ($past(ir_carrier_enable) && ir_carrier_enable
    |-> pb_oe_n[1] || pb_out[1] == $past(ir_carrier)) else $error("carrier missing on pb1");
  c_irq: cover property ($rose(irq));
  c_reset_req: cover property ($rose(ext_reset_req));
  c_read: cover property (reg_read ##1 reg_rdata != 8'h00);
endmodule

// ### verif/gpw_pad_model.sv
// pad wires: design drive, outside drive, pulls, else a churning level
`timescale 1ns/1ps
module gpw_pad_model #(
  parameter int W = 8
) (
  input wire logic sys_clk,
  input wire logic [W-1:0] dut_out,
  input wire logic [W-1:0] dut_oe_n,
  input wire logic [W-1:0] pull_hi,
  input wire logic [W-1:0] pull_lo,
  input wire logic [W-1:0] drv_en,
  input wire logic [W-1:0] drv_val,
  output logic [W-1:0] pad
);
  logic churn = 1'b0;
  // a floating pin must not settle to a friendly constant
  always @(posedge sys_clk) churn <= ~churn;
  always_comb
  begin
    for (int i = 0; i < W; i++)
    begin
      if (!dut_oe_n[i]) pad[i] = dut_out[i];
      else if (drv_en[i]) pad[i] = drv_val[i];
      else if (pull_hi[i]) pad[i] = 1'b1;
      else if (pull_lo[i]) pad[i] = 1'b0;
      else pad[i] = churn;
    end
  end
endmodule

// ### verif/tb_gpio_port_with_wakeup_muxing.sv
// self-checking bench for the gpio port block
`timescale 1ns/1ps
module tb_gpio_port_with_wakeup_muxing;
  import gpw_pkg::*;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] reg_rdata, pa_in, pa_out, pa_oe_n, pa_pullhigh_en, pa_pulllow_en;
  logic [7:0] pa_drv = 8'h00;
  logic [7:0] pa_den = 8'hFF;
  logic [5:0] pb_in, pb_out, pb_oe_n, pb_pullhigh_en, pb_pulllow_en;
  logic [5:0] pb_drv = 6'h00;
  logic irq, ext_reset_req, crystal_mode, ir_carrier_enable, large_sink_a, large_sink_b;
  logic ext_timer_clock_a_t0, ext_timer_clock_a_t1, ext_timer_clock_b;
  logic ext_reset_enable = 1'b0, ext_crystal = 1'b0, ir_carrier = 1'b0;
  logic sink_current_select_a = 1'b0, sink_short_select_a = 1'b0;
  logic sink_current_select_b = 1'b0, sink_short_select_b = 1'b0;
  logic comparator_out = 1'b0, pwm1_out = 1'b0, buzzer1_out = 1'b0;
  logic pwm2_out = 1'b0, buzzer2_out = 1'b0, clock_out_enable = 1'b0, instr_clk_level = 1'b0;
  logic [7:0] alt_v [6] = '{8'h0E, 8'h0C, 8'h08, 8'h30, 8'h20, 8'h01};
  int pin_v [6] = '{3, 3, 3, 2, 2, 1};
  logic exp_v [6] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
  int err_count = 0;
  int num_checks = 0;
  int cycles = 0;
  always #5 sys_clk = ~sys_clk;
  gpw_port DUT (.ext_high_crystal(1'b0), .ext_low_crystal(1'b0), .*);
  gpw_pad_model #(.W(8)) u_pad_a (.sys_clk, .dut_out(pa_out), .dut_oe_n(pa_oe_n),
    .pull_hi(pa_pullhigh_en), .pull_lo(pa_pulllow_en), .drv_en(pa_den), .drv_val(pa_drv),
    .pad(pa_in));
  gpw_pad_model #(.W(6)) u_pad_b (.sys_clk, .dut_out(pb_out), .dut_oe_n(pb_oe_n),
    .pull_hi(pb_pullhigh_en), .pull_lo(pb_pulllow_en), .drv_en(6'h3F), .drv_val(pb_drv),
    .pad(pb_in));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    #1;
    chk(what, reg_rdata, exp);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      err_count++;
      finish_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (6) @(posedge sys_clk);
    reset <= 1'b0;
    rd(OFS_PA_DIR, 8'hFF, "pa dir");
    rd(OFS_PB_DIR, 8'h3F, "pb dir");
    chk("pa oe", pa_oe_n, 8'hFF);
    $display("reset done");
    wr(OFS_PA_PH, 8'h20);
    wr(OFS_PWR, 8'h10);
    wr(OFS_PL, 8'hA5);
    wr(OFS_PB_PH, 8'h3F);
    cyc(2);
    chk("pa ph", pa_pullhigh_en, 8'h20);
    chk("pb ph", pb_pullhigh_en, 6'h3F);
    chk("pa pl", pa_pulllow_en, 8'h25);
    chk("pb pl", pb_pulllow_en, 6'h0A);
    $display("pull done");
    wr(OFS_PA_DIR, 8'h00);
    wr(OFS_PA_DATA, 8'hA5);
    cyc(2);
    chk("pa oe", pa_oe_n, 8'h20);
    chk("pa out", pa_out & 8'hDF, 8'h85);
    chk("pa pl out", pa_pulllow_en, 8'h00);
    rd(OFS_PA_DATA, 8'hA5, "pa data");
    wr(OFS_PB_DIR, 8'h00);
    wr(OFS_PB_OD, 8'h3F);
    wr(OFS_PB_DATA, 8'h2A);
    cyc(2);
    chk("pb od", pb_oe_n, 6'h2A);
    wr(OFS_PB_OD, 8'h00);
    cyc(2);
    chk("pb oe", pb_oe_n, 6'h00);
    chk("pb out", pb_out, 6'h2A);
    $display("output done");
    // second pass inverts the peripheral levels
    for (int p = 0; p < 2; p++)
      for (int i = 0; i < 6; i++)
      begin
        @(posedge sys_clk);
        {comparator_out, pwm1_out, buzzer1_out} <= 3'b010 ^ {3{p[0]}};
        {pwm2_out, buzzer2_out, ir_carrier} <= 3'b010 ^ {3{p[0]}};
        wr(OFS_ALT, alt_v[i]);
        cyc(2);
        chk("pb alt", pb_out[pin_v[i]], exp_v[i] ^ p[0]);
      end
    chk("ir en", ir_carrier_enable, 1'b1);
    wr(OFS_ALT, 8'h00);
    cyc(2);
    chk("ir off", ir_carrier_enable, 1'b0);
    $display("alternate done");
    wr(OFS_PA_DIR, 8'hFF);
    pa_drv <= 8'h12;
    wr(OFS_TSRC, 8'h1D);
    cyc(4);
    chk("tclk a0", ext_timer_clock_a_t0, 1'b1);
    chk("tclk a1", ext_timer_clock_a_t1, 1'b1);
    chk("tclk b", ext_timer_clock_b, 1'b1);
    wr(OFS_TSRC, 8'h03);
    cyc(4);
    chk("tclk a0 low", ext_timer_clock_a_t0, 1'b0);
    chk("tclk a1 off", ext_timer_clock_a_t1, 1'b0);
    chk("tclk b off", ext_timer_clock_b, 1'b0);
    $display("timer source done");
    wr(OFS_IRQ_FLAG, 8'h0E);
    wr(OFS_PA_WAKE, 8'h01);
    wr(OFS_IRQ_EN, 8'h02);
    wr(OFS_PWR, 8'h90);
    pa_drv <= 8'h13;
    cyc(5);
    chk("irq", irq, 1'b1);
    rd(OFS_IRQ_FLAG, 8'h02, "flag set");
    wr(OFS_IRQ_EN, 8'h00);
    cyc(2);
    chk("irq masked", irq, 1'b0);
    wr(OFS_IRQ_FLAG, 8'h02);
    rd(OFS_IRQ_FLAG, 8'h00, "flag clear");
    wr(OFS_IRQ_EN, 8'h02);
    wr(OFS_PWR, 8'h10);
    pa_drv <= 8'h12;
    cyc(5);
    chk("irq global off", irq, 1'b0);
    wr(OFS_PWR, 8'h80);
    cyc(2);
    chk("irq global on", irq, 1'b1);
    $display("wake done");
    wr(OFS_PB_DIR, 8'h3F);
    wr(OFS_IRQ_EDGE, 8'h30);
    wr(OFS_PB_WAKE, 8'h03);
    wr(OFS_IRQ_FLAG, 8'h0E);
    pb_drv <= 6'h03;
    cyc(5);
    rd(OFS_IRQ_FLAG, 8'h0C, "ext wins");
    wr(OFS_PB_WAKE, 8'h04);
    pb_drv <= 6'h07;
    cyc(5);
    rd(OFS_IRQ_FLAG, 8'h0E, "pb2 change");
    $display("external irq done");
    wr(OFS_PWR, 8'h00);
    ext_reset_enable <= 1'b1;
    pa_den <= 8'hDF;
    cyc(6);
    chk("ext reset", ext_reset_req, 1'b1);
    ext_reset_enable <= 1'b0;
    cyc(2);
    chk("ext reset off", ext_reset_req, 1'b0);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge sys_clk);
      {sink_current_select_a, sink_short_select_a} <= 2'(i);
      {sink_current_select_b, sink_short_select_b} <= 2'(3 - i);
      ext_crystal <= i[0];
      {clock_out_enable, instr_clk_level} <= {1'b1, i[1]};
      cyc(1);
      chk("sink a", large_sink_a, i == 2);
      chk("sink b", large_sink_b, i == 1);
      chk("crystal", crystal_mode, i[0]);
      // crystal releases pa7, leaving the high latch bit
      chk("pa7", {pa_oe_n[7], pa_out[7]}, i[0] ? 2'b11 : {1'b0, i[1]});
    end
    $display("config done");
    finish_test();
  end
endmodule
bind gpw_port gpw_port_properties u_props (.*);
